// File: pkg/link_monitor_consts.svh
// Register offsets, field positions, reset values and timing counts of the link monitor.
// Assumes an 8-lane receiver split into two pages of four link lanes.
`ifndef LINK_MONITOR_CONSTS_SVH
`define LINK_MONITOR_CONSTS_SVH

`define ADDR_DISP_STATUS_CTRL   12'h46D
`define ADDR_NIT_STATUS_CTRL    12'h46E
`define ADDR_UCC_STATUS_CTRL    12'h46F
`define ADDR_CGS_FLAGS          12'h470
`define ADDR_FRAME_SYNC_FLAGS   12'h471
`define ADDR_CHECKSUM_FLAGS     12'h472
`define ADDR_ALIGN_FLAGS        12'h473
`define ADDR_THRESHOLD_MASK     12'h477
`define ADDR_IRQ_ENABLE_STATUS  12'h47A
`define ADDR_SYNC_REQUEST_MASK  12'h47B
`define ADDR_ERROR_THRESHOLD    12'h47C
`define ADDR_LINK_PAGE          12'h300
`define ADDR_PULSE_WIDTH        12'h312

`define BIT_LANE_IRQ_CLEAR      7
`define BIT_LANE_COUNT_INHIBIT  6
`define BIT_LANE_COUNTER_CLEAR  5
`define BIT_CGS_IRQ_CLEAR       7
`define BIT_LINK_PAGE           2
`define BIT_CHECKSUM_MODE       6
`define BIT_THRESHOLD_MASK_EN   3
`define LSB_PULSE_WIDTH         4
`define MSB_PULSE_WIDTH         5

`define THRESHOLD_RESET         8'hFF
`define COUNTER_MAX             8'hFF
`define PULSE_WIDTH_RESET       2'h0
`define DISPARITY_REINIT_COUNT  3'h4
`define REINIT_FRAMES           5
`define REINIT_OCTETS           9

`endif

// File: pkg/link_monitor_pkg.sv
// Types shared by the link monitor logic.
// Assumes the constants header is included alongside.
package link_monitor_pkg;

    typedef struct packed {
        logic [7:0] disp;
        logic [7:0] table_miss_error;
        logic [7:0] ucc;
    } lane_errors_t;

    typedef struct packed {
        logic [7:0] cgs;
        logic [7:0] frame_sync;
        logic [7:0] align;
    } lane_status_t;

    typedef struct packed {
        logic [7:0] did;
        logic [7:0] bid;
        logic [7:0] scr;
        logic [7:0] l_m1;
        logic [7:0] f_m1;
        logic [7:0] k_m1;
        logic [7:0] m_m1;
        logic [7:0] n_m1;
        logic [7:0] subclass;
        logic [7:0] np_m1;
        logic [7:0] version;
        logic [7:0] s_m1;
        logic [7:0] hd;
        logic [103:0] packed_bytes;
    } link_params_t;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_RESYNC = 3'b010,
        ST_HOLD   = 3'b100
    } sync_state_t;

endpackage : link_monitor_pkg

// File: logic/jesd_rx_error_link_monitor.sv
// Error monitor and link establishment status for an 8-lane receiver.
// Assumes lane decoders deliver per-character error strobes on sys_clk.
// Summary of operation
// - One shared threshold register serves all three error types.
// - Per-lane over-threshold status at three addresses, one per type.
// - Writes to the status registers are commands; reads return status.
// - Link page bit selects lanes 0-3 or 4-7 for per-lane access.
// - Bit 7 written one clears the addressed lane's interrupt.
// - Bit 6 written one stops counting for the addressed lane.
// - Bit 5 written one clears the addressed lane's counter.
// - Any error pulses sync output low for one cycle, or two cycles at pulse width setting 2.
// - Three enable bits gate over-threshold interrupts, status readable there.
// - Four cycles with an invalid disparity character reinitialize the link.
// - Reinitialization holds sync request for five frames plus nine octets.
// - Threshold mask bit arms reinit; unmasked counters then do not saturate.
// - Sync mask bits request resync when any lane's counter hits threshold.
// - Reinitialization clears counters but keeps pending interrupts.
// - Code group sync flag per lane after four K28.5 and sync.
// - Frame sync flag per lane after initial frame sync.
// - Checksum good when equal to low byte of field sum plus lane id.
// - Checksum mode bit selects packed byte sum plus lane id.
// - Lane alignment flag per lane after alignment sequence.
// - Four enable bits gate sync, frame, checksum, alignment failure interrupts.
// - Writes to status registers clear the respective failure interrupt, the CGS one only with bit 7 set.
// - Counters saturate at threshold by default.
`include "link_monitor_consts.svh"

module jesd_rx_error_link_monitor
    import link_monitor_pkg::*;
(
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // Register port
    input  wire logic [11:0]  reg_addr,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [7:0]   reg_wdata,
    output logic      [7:0]   reg_rdata,
    // Lane decoder events, one bit per logical lane; checksum and lane id one byte per lane, one set of link parameters
    input  wire lane_errors_t lane_err,
    input  wire logic [7:0]   bad_disparity_char,
    input  wire lane_status_t lane_stat,
    input  wire logic [63:0]  rx_checksum,
    input  wire logic [63:0]  rx_lane_id,
    input  wire link_params_t link_params,
    // Frame timing
    input  wire logic [3:0]   octets_per_frame,
    input  wire logic [2:0]   frames_per_parallel_cycle,
    // Sync request to the transmitter, low requests resync
    output logic              sync_request_out,
    output logic              link_reinit
);

    localparam int unsigned REINIT_LEN = 16;

    typedef struct packed {
        logic [7:0]            rdata;
        logic                  sync_out;
        logic                  reinit;
        sync_state_t           st;
        logic [REINIT_LEN-1:0] hold_cnt;
        logic [1:0]            pulse_cnt;
        logic [2:0]            disp_run;
        logic [7:0]            threshold;
        logic [7:0]            sync_mask;
        logic [7:0]            irq_en;
        logic                  link_page;
        logic                  chk_mode;
        logic                  thr_mask_en;
        logic [1:0]            pulse_sel;
        logic [2:0][7:0][7:0]  cnt;
        logic [2:0][7:0]       inhibit;
        logic [2:0][7:0]       lane_irq;
        logic [3:0]            fail_irq;
        logic [3:0][7:0]       flag_prev;
    } state_t;

    state_t r, nxt;

    function automatic logic [7:0] lane_view(input logic [7:0] v, input logic page);
        lane_view = page ? {4'h0, v[7:4]} : {4'h0, v[3:0]};
    endfunction : lane_view

    function automatic logic [2:0] logical_lane(input logic [2:0] a, input logic page);
        logical_lane = page ? 3'(a + 3'h4) : a;
    endfunction : logical_lane

    logic [7:0] chk_good;
    logic [7:0] field_sum;
    logic [7:0] packed_sum;

    always_comb
    begin
        field_sum  = link_params.did + link_params.bid + link_params.scr
                   + link_params.l_m1 + link_params.f_m1 + link_params.k_m1
                   + link_params.m_m1 + link_params.n_m1 + link_params.subclass
                   + link_params.np_m1 + link_params.version + link_params.s_m1
                   + link_params.hd;
        packed_sum = 8'h00;
        for (int b = 0; b < 13; b++)
        begin
            packed_sum = packed_sum + link_params.packed_bytes[b*8 +: 8];
        end
        for (int l = 0; l < 8; l++)
        begin
            chk_good[l] = rx_checksum[l*8 +: 8] ==
                (r.chk_mode ? 8'(packed_sum + rx_lane_id[l*8 +: 8])
                            : 8'(field_sum + rx_lane_id[l*8 +: 8]));
        end
    end

    logic [2:0][7:0] err_in;
    logic [2:0][7:0] at_thr;
    logic [2:0]      any_thr;
    logic [2:0]      type_irq;
    logic [3:0][7:0] flag_now;
    logic            any_err;
    logic            resync_thr;
    logic            disp_reinit;
    logic [2:0]      lane_sel;
    logic [2:0]      reg_type;
    logic            is_type_reg;

    always_comb
    begin
        err_in      = {lane_err.ucc, lane_err.table_miss_error, lane_err.disp};
        flag_now    = {lane_stat.align, chk_good, lane_stat.frame_sync, lane_stat.cgs};
        any_err     = |{lane_err.disp, lane_err.table_miss_error, lane_err.ucc};
        lane_sel    = logical_lane(reg_wdata[2:0], r.link_page);
        is_type_reg = reg_wr && (reg_addr >= `ADDR_DISP_STATUS_CTRL)
                             && (reg_addr <= `ADDR_UCC_STATUS_CTRL);
        reg_type    = 3'h0;
        if (is_type_reg)
        begin
            reg_type[2'(reg_addr - `ADDR_DISP_STATUS_CTRL)] = 1'b1;
        end
        for (int t = 0; t < 3; t++)
        begin
            for (int l = 0; l < 8; l++)
            begin
                at_thr[t][l] = r.cnt[t][l] >= r.threshold;
            end
            any_thr[t]  = |at_thr[t];
            type_irq[t] = |r.lane_irq[t];
        end
        resync_thr  = r.thr_mask_en &&
                      |(any_thr & {r.sync_mask[5], r.sync_mask[6], r.sync_mask[7]});
        disp_reinit = |bad_disparity_char && (r.disp_run == `DISPARITY_REINIT_COUNT - 3'h1);

        nxt        = r;
        nxt.reinit = 1'b0;

        // Counters, interrupts and command writes.
        for (int t = 0; t < 3; t++)
        begin
            for (int l = 0; l < 8; l++)
            begin
                if (err_in[t][l] && !r.inhibit[t][l])
                begin
                    if (r.thr_mask_en && r.sync_mask[7-t])
                    begin
                        nxt.cnt[t][l] = 8'(r.cnt[t][l] + 8'h01);
                    end
                    else if (r.cnt[t][l] < r.threshold && r.cnt[t][l] != `COUNTER_MAX)
                    begin
                        nxt.cnt[t][l] = 8'(r.cnt[t][l] + 8'h01);
                    end
                end
                if (reg_type[t] && lane_sel == 3'(l))
                begin
                    if (reg_wdata[`BIT_LANE_COUNT_INHIBIT])
                    begin
                        nxt.inhibit[t][l] = 1'b1;
                    end
                    if (reg_wdata[`BIT_LANE_COUNTER_CLEAR])
                    begin
                        nxt.cnt[t][l] = 8'h00;
                    end
                    if (reg_wdata[`BIT_LANE_IRQ_CLEAR])
                    begin
                        nxt.lane_irq[t][l] = 1'b0;
                    end
                end
                if (at_thr[t][l] && r.irq_en[7-t])
                begin
                    nxt.lane_irq[t][l] = 1'b1;
                end
            end
        end

        // Failure interrupts on falling status flags; set wins over clear.
        nxt.flag_prev = flag_now;
        for (int f = 0; f < 4; f++)
        begin
            if (reg_wr && reg_addr == 12'(`ADDR_CGS_FLAGS + f)
                && (f != 0 || reg_wdata[`BIT_CGS_IRQ_CLEAR]))
            begin
                nxt.fail_irq[f] = 1'b0;
            end
            if (r.irq_en[f] && |(r.flag_prev[f] & ~flag_now[f]))
            begin
                nxt.fail_irq[f] = 1'b1;
            end
        end

        // Configuration registers.
        if (reg_wr)
        begin
            case (reg_addr)
                `ADDR_ERROR_THRESHOLD:   nxt.threshold = reg_wdata;
                `ADDR_SYNC_REQUEST_MASK: nxt.sync_mask = reg_wdata;
                `ADDR_IRQ_ENABLE_STATUS: nxt.irq_en    = reg_wdata;
                `ADDR_LINK_PAGE:
                begin
                    nxt.link_page = reg_wdata[`BIT_LINK_PAGE];
                    nxt.chk_mode  = reg_wdata[`BIT_CHECKSUM_MODE];
                end
                `ADDR_THRESHOLD_MASK:    nxt.thr_mask_en = reg_wdata[`BIT_THRESHOLD_MASK_EN];
                `ADDR_PULSE_WIDTH:
                    nxt.pulse_sel = reg_wdata[`MSB_PULSE_WIDTH:`LSB_PULSE_WIDTH];
                default: ;
            endcase
        end

        // Cycles with an invalid disparity character; clean cycles keep the count.
        if (|bad_disparity_char)
        begin
            nxt.disp_run = disp_reinit ? 3'h0 : 3'(r.disp_run + 3'h1);
        end

        // Sync output sequencing.
        case (r.st)
            ST_RUN:
            begin
                nxt.sync_out = 1'b1;
                if (disp_reinit || resync_thr)
                begin
                    nxt.st       = ST_RESYNC;
                    nxt.sync_out = 1'b0;
                    nxt.reinit   = 1'b1;
                    nxt.hold_cnt = REINIT_LEN'(`REINIT_FRAMES * octets_per_frame
                                 + `REINIT_OCTETS);
                    nxt.cnt      = '0;
                    nxt.disp_run = 3'h0;
                end
                else if (any_err)
                begin
                    nxt.st        = ST_HOLD;
                    nxt.sync_out  = 1'b0;
                    nxt.pulse_cnt = (r.pulse_sel == 2'h2) ? 2'h1 : 2'h0;
                end
            end
            ST_RESYNC:
            begin
                nxt.sync_out = 1'b0;
                nxt.hold_cnt = REINIT_LEN'(r.hold_cnt
                             - {13'h0, frames_per_parallel_cycle});
                if (r.hold_cnt <= {13'h0, frames_per_parallel_cycle})
                begin
                    nxt.st       = ST_RUN;
                    nxt.sync_out = 1'b1;
                end
            end
            ST_HOLD:
            begin
                nxt.pulse_cnt = 2'(r.pulse_cnt - 2'h1);
                if (r.pulse_cnt == 2'h0)
                begin
                    nxt.st       = ST_RUN;
                    nxt.sync_out = 1'b1;
                end
            end
            default:
            begin
                nxt.st       = ST_RUN;
                nxt.sync_out = 1'b1;
            end
        endcase

        // Read data: status at status addresses, enabled pending interrupts at ADDR_IRQ_ENABLE_STATUS, written fields at other configuration addresses.
        case (reg_addr)
            `ADDR_DISP_STATUS_CTRL:  nxt.rdata = lane_view(at_thr[0], r.link_page);
            `ADDR_NIT_STATUS_CTRL:   nxt.rdata = lane_view(at_thr[1], r.link_page);
            `ADDR_UCC_STATUS_CTRL:   nxt.rdata = lane_view(at_thr[2], r.link_page);
            `ADDR_CGS_FLAGS:         nxt.rdata = lane_view(flag_now[0], r.link_page);
            `ADDR_FRAME_SYNC_FLAGS:  nxt.rdata = lane_view(flag_now[1], r.link_page);
            `ADDR_CHECKSUM_FLAGS:    nxt.rdata = lane_view(flag_now[2], r.link_page);
            `ADDR_ALIGN_FLAGS:       nxt.rdata = lane_view(flag_now[3], r.link_page);
            `ADDR_IRQ_ENABLE_STATUS:
                nxt.rdata = r.irq_en & {type_irq[0], type_irq[1], type_irq[2],
                                        1'b0, r.fail_irq};
            `ADDR_SYNC_REQUEST_MASK: nxt.rdata = r.sync_mask;
            `ADDR_ERROR_THRESHOLD:   nxt.rdata = r.threshold;
            `ADDR_LINK_PAGE:
                nxt.rdata = {1'b0, r.chk_mode, 3'h0, r.link_page, 2'h0};
            `ADDR_THRESHOLD_MASK:    nxt.rdata = {4'h0, r.thr_mask_en, 3'h0};
            `ADDR_PULSE_WIDTH:       nxt.rdata = {2'h0, r.pulse_sel, 4'h0};
            default:                 nxt.rdata = 8'h00;
        endcase
        if (!reg_rd)
        begin
            nxt.rdata = r.rdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            r           <= '0;
            r.st        <= ST_RUN;
            r.sync_out  <= 1'b1;
            r.threshold <= `THRESHOLD_RESET;
            r.pulse_sel <= `PULSE_WIDTH_RESET;
            r.flag_prev <= '0;
        end
        else
        begin
            r <= nxt;
        end
    end

    always_comb
    begin
        reg_rdata        = r.rdata;
        sync_request_out = r.sync_out;
        link_reinit      = r.reinit;
    end

endmodule : jesd_rx_error_link_monitor

// File: verif/link_monitor_chk.sv
// Port-level assertions for the link monitor.
// Assumes framing inputs stay steady and reg_rd and reg_wr never share a cycle.
module link_monitor_chk
    import link_monitor_pkg::*;
(
    // Clock and reset
    input wire logic         sys_clk,
    input wire logic         rstn,
    // Register port
    input wire logic [11:0]  reg_addr,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [7:0]   reg_wdata,
    input wire logic [7:0]   reg_rdata,
    // Lane side
    input wire lane_errors_t lane_err,
    input wire lane_status_t lane_stat,
    input wire logic [3:0]   octets_per_frame,
    input wire logic [2:0]   frames_per_parallel_cycle,
    input wire logic         sync_request_out,
    input wire logic         link_reinit
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       page_r;
    logic [7:0] thr_r;
    int         lo_r;
    int         exp_len;
    logic [7:0] view;
    logic [3:0] view4;
    assign exp_len = (5 * int'(octets_per_frame) + 8 + int'(frames_per_parallel_cycle))
                     / int'(frames_per_parallel_cycle);
    always_comb
    begin
        case (reg_addr)
            12'h470: view = lane_stat.cgs;
            12'h471: view = lane_stat.frame_sync;
            default: view = lane_stat.align;
        endcase
    end
    assign view4 = page_r ? view[7:4] : view[3:0];
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            page_r <= 1'b0;
            thr_r  <= 8'hFF;
            lo_r   <= 0;
        end
        else
        begin
            lo_r <= sync_request_out ? 0 : lo_r + 1;
            if (reg_wr && reg_addr == 12'h300) page_r <= reg_wdata[2];
            if (reg_wr && reg_addr == 12'h47C) thr_r <= reg_wdata;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_hold;
        !sync_request_out [*8];
    endsequence
    sequence s_rd(logic [11:0] a);
        reg_rd && reg_addr == a;
    endsequence
    property p_err_pulse;
        sync_request_out && (lane_err != '0) |=> !sync_request_out;
    endproperty
    property p_reinit_hold;
        link_reinit |=> s_hold;
    endproperty
    property p_reinit_pulse;
        link_reinit |=> !link_reinit;
    endproperty
    // A resync starts only while the sync output is high, so an error pulse is never added in front.
    property p_low_len;
        $rose(sync_request_out) |-> lo_r <= exp_len + 2;
    endproperty
    property p_rd_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    property p_unmapped;
        reg_rd && !(reg_addr inside {[12'h46D:12'h473], 12'h477, [12'h47A:12'h47C],
            12'h300, 12'h312}) |=> reg_rdata == 8'h00;
    endproperty
    property p_stat_view;
        reg_rd && reg_addr inside {12'h470, 12'h471, 12'h473} |=> reg_rdata[3:0] == $past(view4);
    endproperty
    property p_thr_read;
        s_rd(12'h47C) |=> reg_rdata == $past(thr_r);
    endproperty
    a_err_pulse: assert property (p_err_pulse)
        else $error("no sync pulse after a lane error");
    a_reinit_hold: assert property (p_reinit_hold)
        else $error("resync request ended early");
    a_reinit_pulse: assert property (p_reinit_pulse)
        else $error("reinit strobe longer than one cycle");
    a_low_len: assert property (p_low_len)
        else $error("sync request held too long");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address read nonzero");
    a_stat_view: assert property (p_stat_view)
        else $error("lane status view mismatch");
    a_thr_read: assert property (p_thr_read)
        else $error("threshold readback mismatch");
endmodule : link_monitor_chk

bind jesd_rx_error_link_monitor link_monitor_chk i_link_monitor_chk (.sys_clk, .rstn,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .lane_err, .lane_stat,
    .octets_per_frame, .frames_per_parallel_cycle, .sync_request_out, .link_reinit);

// File: verif/jesd_tx_model.sv
// Transmitter-side model: error strobes, lane status levels and ILAS checksums.
// Assumes its tasks are called just after a rising edge of sys_clk.
module jesd_tx_model
    import link_monitor_pkg::*;
(
    // Clock
    input  wire logic    sys_clk,
    // Lane outputs
    output lane_errors_t lane_err,
    output logic [7:0]   bad_disparity_char,
    output lane_status_t lane_stat,
    output logic [63:0]  rx_checksum,
    output logic [63:0]  rx_lane_id,
    output link_params_t link_params
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] ev = 32'h0;
    assign lane_err = ev[23:0];
    assign bad_disparity_char = ev[31:24];
    // Every ILAS field is one and the packed bytes are zero.
    assign link_params = {{13{8'h01}}, 104'h0};
    always_comb
    begin
        for (int l = 0; l < 8; l++)
        begin
            rx_lane_id[l*8+:8] = 8'(l);
            // Lanes 0 to 3 send the field sum, lanes 4 to 7 the packed sum.
            rx_checksum[l*8+:8] = (l < 4) ? 8'(13 + l) : 8'(l);
        end
    end
    initial lane_stat = '0;
    task send_err(input int t, input int l);
        ev[(t == 3) ? 24 + l : (2 - t) * 8 + l] <= 1'b1;
        @(posedge sys_clk);
        ev <= 32'h0;
        #1;
    endtask : send_err
    task set_stat(input lane_status_t v);
        lane_stat <= v;
        @(posedge sys_clk);
        #1;
    endtask : set_stat
endmodule : jesd_tx_model

// File: verif/jesd_rx_error_link_monitor_tb.sv
// Register-level testbench for the link monitor with a transmitter model.
// Assumes two octets per frame and two frames per cycle, a ten-cycle resync.
module jesd_rx_error_link_monitor_tb;
    import link_monitor_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic         sys_clk   = 1'b0;
    logic         rstn      = 1'b0;
    logic [11:0]  reg_addr  = 12'h000;
    logic         reg_wr    = 1'b0;
    logic         reg_rd    = 1'b0;
    logic [7:0]   reg_wdata = 8'h00;
    logic [7:0]   reg_rdata;
    lane_errors_t lane_err;
    logic [7:0]   bad_disparity_char;
    lane_status_t lane_stat;
    logic [63:0]  rx_checksum;
    logic [63:0]  rx_lane_id;
    link_params_t link_params;
    logic         sync_request_out;
    logic         link_reinit;
    int           error_cnt = 0;
    int           n_checks  = 0;
    int           n;
    logic         seen;

    always #4 sys_clk = ~sys_clk;

    jesd_rx_error_link_monitor i_jesd_rx_error_link_monitor (.sys_clk, .rstn, .reg_addr,
        .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .lane_err, .bad_disparity_char, .lane_stat,
        .rx_checksum, .rx_lane_id, .link_params, .octets_per_frame(4'h2),
        .frames_per_parallel_cycle(3'h2), .sync_request_out, .link_reinit);
    jesd_tx_model i_jesd_tx_model (.sys_clk, .lane_err, .bad_disparity_char, .lane_stat,
        .rx_checksum, .rx_lane_id, .link_params);

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [11:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, reg_rdata);
    endtask : rd
    // Counts the low run of the sync output, looking before each wait.
    task meas(output int cnt, output logic re);
        cnt = 0;
        re  = 1'b0;
        for (int k = 0; k < 40; k++)
        begin
            if (link_reinit === 1'b1) re = 1'b1;
            if (sync_request_out === 1'b0) cnt++;
            else if (cnt > 0) break;
            @(posedge sys_clk);
            #1;
        end
        // A low run that outlasts the bound is a hang: report it and stop.
        if (sync_request_out !== 1'b1)
        begin
            error_cnt++;
            $display("ERROR sync wait expected 1 seen %b", sync_request_out);
            tally_and_finish();
        end
    endtask : meas
    task hit(input int t, input int l, input logic [7:0] e);
        i_jesd_tx_model.send_err(t, l);
        meas(n, seen);
        chk("pulse cycles", e, 8'(n));
    endtask : hit
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        rd(12'h47C, 8'hFF);
        rd(12'h123, 8'h00);
        rd(12'h46D, 8'h00);
        wr(12'h47A, 8'hE0);
        wr(12'h47C, 8'h03);
        repeat (3) hit(0, 1, 8'h01);
        rd(12'h46D, 8'h02);
        rd(12'h46E, 8'h00);
        repeat (3) hit(1, 5, 8'h01);
        wr(12'h300, 8'h04);
        rd(12'h46E, 8'h02);
        rd(12'h46D, 8'h00);
        wr(12'h46E, 8'h01);
        rd(12'h46E, 8'h02);
        wr(12'h300, 8'h00);
        rd(12'h47A, 8'hC0);
        wr(12'h46D, 8'h21);
        rd(12'h46D, 8'h00);
        wr(12'h46D, 8'h81);
        rd(12'h47A, 8'h40);
        wr(12'h46D, 8'h41);
        repeat (3) hit(0, 1, 8'h01);
        rd(12'h46D, 8'h00);
        repeat (3) hit(0, 2, 8'h01);
        rd(12'h46D, 8'h04);
        hit(0, 2, 8'h01);
        wr(12'h47C, 8'h04);
        rd(12'h46D, 8'h00);
        wr(12'h47C, 8'h03);
        rd(12'h47A, 8'hC0);
        $display("test counters done");
        for (int s = 0; s < 3; s++)
        begin
            wr(12'h312, 8'(s << 4));
            hit(2, 0, (s == 2) ? 8'h02 : 8'h01);
        end
        rd(12'h47A, 8'hE0);
        $display("test pulse width done");
        repeat (4) i_jesd_tx_model.send_err(3, 0);
        meas(n, seen);
        chk("reinit seen", 8'h01, {7'h0, seen});
        chk("reinit cycles", 8'h0A, 8'(n));
        rd(12'h46D, 8'h00);
        rd(12'h46F, 8'h00);
        rd(12'h47A, 8'hE0);
        $display("test reinit done");
        wr(12'h477, 8'h08);
        wr(12'h47B, 8'h20);
        rd(12'h47B, 8'h20);
        repeat (2) hit(2, 3, 8'h02);
        i_jesd_tx_model.send_err(2, 3);
        meas(n, seen);
        chk("pulse cycles", 8'h02, 8'(n));
        meas(n, seen);
        chk("resync seen", 8'h01, {7'h0, seen});
        chk("resync cycles", 8'h0A, 8'(n));
        $display("test threshold resync done");
        i_jesd_tx_model.set_stat({8'hA5, 8'h3C, 8'hF0});
        rd(12'h470, 8'h05);
        rd(12'h471, 8'h0C);
        rd(12'h473, 8'h00);
        rd(12'h472, 8'h0F);
        wr(12'h300, 8'h04);
        rd(12'h470, 8'h0A);
        rd(12'h471, 8'h03);
        rd(12'h473, 8'h0F);
        rd(12'h472, 8'h00);
        wr(12'h300, 8'h44);
        rd(12'h472, 8'h0F);
        wr(12'h300, 8'h00);
        $display("test status done");
        i_jesd_tx_model.set_stat({8'hFF, 8'hFF, 8'hFF});
        wr(12'h47A, 8'hEF);
        for (int a = 0; a < 4; a++) wr(12'h470 + 12'(a), (a == 0) ? 8'h80 : 8'h01);
        rd(12'h47A, 8'hE0);
        wr(12'h300, 8'h40);
        i_jesd_tx_model.set_stat({8'h00, 8'h00, 8'h00});
        rd(12'h47A, 8'hEF);
        for (int a = 0; a < 4; a++) wr(12'h470 + 12'(a), (a == 0) ? 8'h80 : 8'h01);
        rd(12'h47A, 8'hE0);
        $display("test failure interrupts done");
        tally_and_finish();
    end
endmodule : jesd_rx_error_link_monitor_tb
